// [verilog/game_irq_pkg.sv]
package game_irq_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam logic [5:0] IDX_ENABLE = 6'h03;
  localparam logic [5:0] IDX_CNT_FIRST = 6'h04;
  localparam logic [5:0] IDX_CNT_LAST = 6'h0B;
  localparam logic [5:0] IDX_EDGE_SEL = 6'h0C;
  localparam logic [5:0] IDX_MODE = 6'h0D;

  // Address layout of the APB byte address.
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] ADDR_ALIGNED = 2'h0;

  // Reset values.
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // Enable register fields; bit 3 is reserved and reads as zero.
  localparam int EN_POS_A = 0;
  localparam int EN_POS_B = 1;
  localparam int EN_POS_DEF = 2;
  localparam int EN_BTN_LSB = 4;
  localparam logic [7:0] ENABLE_WMASK = 8'hF7;

  // Status register fields: ready flags low, button event flags high.
  localparam int ST_AX = 0;
  localparam int ST_AY = 1;
  localparam int ST_BX = 2;
  localparam int ST_BY = 3;
  localparam int ST_BTN_LSB = 4;
  localparam int NUM_BTN = 4;
  localparam int NUM_AXIS = 4;

  // Mode register field.
  localparam int MODE_ENH = 0;

  // Two-bit button edge codes.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// [verilog/game_button_event.sv]
`timescale 1ns/1ps
module game_button_event
  import game_irq_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] buttons,
  input wire logic [2*N-1:0] edge_sel,
  output logic [N-1:0] event_pulse
);

  typedef struct packed {
    logic primed;
    logic [N-1:0] prev;
    logic [N-1:0] evt;
  } btn_state_t;

  btn_state_t s_r;
  btn_state_t s_nxt;
  logic [N-1:0] hit;

  // Each button compares its level against the last one under its own edge code.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_btn
      logic rise;
      logic fall;
      logic [1:0] code;
      assign code = edge_sel[2*g+1:2*g];
      assign rise = buttons[g] & ~s_r.prev[g];
      assign fall = ~buttons[g] & s_r.prev[g];
      assign hit[g] = ((code == EDGE_RISE) & rise) | // [R07]
                      ((code == EDGE_FALL) & fall) |
                      ((code == EDGE_BOTH) & (rise | fall));
    end
  endgenerate

  // The first cycle after reset only samples, so a button held at reset is no edge.
  always_comb begin
    s_nxt = s_r;
    s_nxt.primed = 1'b1;
    s_nxt.prev = buttons;
    s_nxt.evt = s_r.primed ? hit : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign event_pulse = s_r.evt;

endmodule

// [verilog/game_irq_ctrl.sv]
`timescale 1ns/1ps
// How it works
// [R01] Enable settings act only in enhanced mode.
// [R02] Bit 7 gates joystick B button 1.
// [R03] Bits 6..4 gate the other three buttons.
// [R04] Bit 2 picks both-axes or either-axis ready.
// [R05] Bit 1 gates joystick B position done.
// [R06] Bit 0 gates joystick A position done.
// [R07] Two-bit code picks none, rise, fall, both.
// [R08] Status flags: write one clears, counter read clears.
// [R09] Request is OR of all enabled conditions.
module game_irq_ctrl
  import game_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_BTN-1:0] button_in,
  input wire logic [NUM_AXIS-1:0] pos_done,
  input wire logic [15:0] ax_count,
  input wire logic [15:0] ay_count,
  input wire logic [15:0] bx_count,
  input wire logic [15:0] by_count,
  output logic irq
);

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] status;
    logic [7:0] edge_sel;
    logic enhanced;
    logic [NUM_AXIS-1:0][15:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;
  logic [NUM_BTN-1:0] btn_evt;
  logic [NUM_AXIS-1:0][15:0] count_in;

  assign count_in[ST_AX] = ax_count;
  assign count_in[ST_AY] = ay_count;
  assign count_in[ST_BX] = bx_count;
  assign count_in[ST_BY] = by_count;

  // Button edge detection runs from the edge select register.
  game_button_event #(
    .N(NUM_BTN)
  ) u_btn (
    .pclk(pclk),
    .presetn(presetn),
    .buttons(button_in),
    .edge_sel(s_r.edge_sel),
    .event_pulse(btn_evt)
  );

  logic [5:0] idx;
  logic aligned;
  logic is_cnt;
  logic hit;
  logic setup;
  logic done;
  logic [5:0] cnt_off;
  logic [1:0] cnt_sel;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic pos_a;
  logic pos_b;

  // Address decode; anything not listed, or not word aligned, is answered with an error.
  always_comb begin
    idx = paddr[ADDR_W-1:IDX_LSB];
    aligned = (paddr[IDX_LSB-1:0] == ADDR_ALIGNED);
    is_cnt = (idx >= IDX_CNT_FIRST) && (idx <= IDX_CNT_LAST);
    cnt_off = idx - IDX_CNT_FIRST;
    cnt_sel = cnt_off[2:1];
    hit = aligned && (is_cnt || (idx == IDX_STATUS) || (idx == IDX_ENABLE) ||
          (idx == IDX_EDGE_SEL) || (idx == IDX_MODE));
    setup = psel && !penable && !s_r.pready;
    done = psel && penable && s_r.pready;
  end

  // Register file, status flags and the request output, all in one next-state process.
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    set_bits = '0;
    clr_bits = '0;
    pos_a = 1'b0;
    pos_b = 1'b0;

    // Read data is prepared in the setup cycle so pready can rise in the first access cycle.
    if (setup) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !hit;
      s_nxt.prdata = RDATA_ZERO;
      if (hit) begin
        if (is_cnt) begin
          s_nxt.prdata[7:0] = cnt_off[0] ? s_r.cnt[cnt_sel][15:8] : s_r.cnt[cnt_sel][7:0];
        end else begin
          case (idx)
            IDX_STATUS: begin
              s_nxt.prdata[7:0] = s_r.status;
            end
            IDX_ENABLE: begin
              s_nxt.prdata[7:0] = s_r.enable;
            end
            IDX_EDGE_SEL: begin
              s_nxt.prdata[7:0] = s_r.edge_sel;
            end
            IDX_MODE: begin
              s_nxt.prdata[MODE_ENH] = s_r.enhanced;
            end
            default: begin
              s_nxt.prdata = RDATA_ZERO;
            end
          endcase
        end
      end
    end

    // Writes and read side effects happen only at the completing edge.
    if (done && hit) begin
      if (pwrite) begin
        case (idx)
          IDX_STATUS: begin
            clr_bits = pwdata[7:0]; // [R08]
          end
          IDX_ENABLE: begin
            s_nxt.enable = pwdata[7:0] & ENABLE_WMASK;
          end
          IDX_EDGE_SEL: begin
            s_nxt.edge_sel = pwdata[7:0];
          end
          IDX_MODE: begin
            s_nxt.enhanced = pwdata[MODE_ENH];
          end
          default: begin
            clr_bits = '0;
          end
        endcase
      end else if (is_cnt && cnt_off[0]) begin
        // Reading the high byte ends the low-then-high pair, so it clears the ready flag.
        clr_bits[cnt_sel] = 1'b1; // [R08]
      end
    end

    // Events are only recorded in enhanced mode; counters latch on completion.
    if (s_r.enhanced) begin
      set_bits[ST_BTN_LSB +: NUM_BTN] = btn_evt;
      set_bits[NUM_AXIS-1:0] = pos_done;
      for (int k = 0; k < NUM_AXIS; k++) begin
        if (pos_done[k]) begin
          s_nxt.cnt[k] = count_in[k];
        end
      end
    end
    // A new event beats a clear in the same cycle, so no event is lost.
    s_nxt.status = (s_r.status & ~clr_bits) | set_bits; // [R08]

    // Position condition per joystick, chosen by the definition bit.
    if (s_nxt.enable[EN_POS_DEF]) begin
      pos_a = s_nxt.status[ST_AX] | s_nxt.status[ST_AY]; // [R04]
      pos_b = s_nxt.status[ST_BX] | s_nxt.status[ST_BY];
    end else begin
      pos_a = s_nxt.status[ST_AX] & s_nxt.status[ST_AY]; // [R04]
      pos_b = s_nxt.status[ST_BX] & s_nxt.status[ST_BY];
    end

    // The request is gated off entirely in legacy mode.
    s_nxt.irq = s_nxt.enhanced & ( // [R01]
                |(s_nxt.enable[EN_BTN_LSB +: NUM_BTN] & // [R02] [R03]
                  s_nxt.status[ST_BTN_LSB +: NUM_BTN]) |
                (s_nxt.enable[EN_POS_B] & pos_b) | // [R05]
                (s_nxt.enable[EN_POS_A] & pos_a)); // [R06] [R09]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.enable <= ENABLE_RESET;
      s_r.status <= STATUS_RESET;
      s_r.edge_sel <= EDGE_SEL_RESET;
      s_r.enhanced <= 1'b0;
      s_r.cnt <= {NUM_AXIS{CNT_RESET}};
      s_r.prdata <= RDATA_ZERO;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;

endmodule

// [sim/game_irq_props.sv]
`timescale 1ns/1ps
module game_irq_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] pos_done,
  input wire logic irq
);
  logic [7:0] en_r;
  logic mode_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Mirror enable and mode from completed writes, since the irq checks need the mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 8'h00;
      mode_r <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == 8'h0C) en_r <= pwdata[7:0];
      if (paddr == 8'h34) mode_r <= pwdata[0];
    end
  end
  one_cycle_a:
    assert property (pready |=> !pready) else $error("pready too long");
  ready_answer_a:
    assert property (psel && !penable |=> pready) else $error("no answer");
  ready_cause_a:
    assert property ($rose(pready) |-> $past(psel && !penable)) else $error("stray pready");
  unaligned_err_a:
    assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr) else $error("no err");
  legacy_quiet_a:
    assert property (!mode_r |-> !irq) else $error("irq in legacy mode");
  mask_quiet_a:
    assert property ((en_r & 8'hF3) == 8'h00 |-> !irq) else $error("irq while masked");
  pos_a_irq_a:
    assert property (mode_r && en_r[0] && en_r[2] && pos_done[1] |=> irq) else $error("no irq A");
  pos_b_irq_a:
    assert property (mode_r && en_r[1] && en_r[2] && pos_done[2] |=> irq) else $error("no irq B");
endmodule
bind game_irq_ctrl game_irq_props game_irq_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .pos_done, .irq);

// [sim/joystick_model.sv]
`timescale 1ns/1ps
module joystick_model (
  input wire logic pclk,
  output logic [3:0] button_in,
  output logic [3:0] pos_done,
  output logic [15:0] ax_count,
  output logic [15:0] ay_count,
  output logic [15:0] bx_count,
  output logic [15:0] by_count
);
  logic [15:0] val = 16'h0000;
  // Buttons start released and no measurement is pending.
  initial begin
    button_in = 4'h0;
    pos_done = 4'h0;
  end
  // Counts only mean something in the done cycle, so otherwise the inverse shows, never old data.
  assign ax_count = pos_done[0] ? val : ~val;
  assign ay_count = pos_done[1] ? val : ~val;
  assign bx_count = pos_done[2] ? val : ~val;
  assign by_count = pos_done[3] ? val : ~val;
  task automatic press(input logic [3:0] b);
    @(posedge pclk);
    button_in <= b;
  endtask
  task automatic done(input logic [3:0] m, input logic [15:0] v);
    @(posedge pclk);
    val <= v;
    pos_done <= m;
    @(posedge pclk);
    pos_done <= 4'h0;
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import game_irq_pkg::*;
  localparam logic [7:0] a_st = {IDX_STATUS, 2'h0};
  localparam logic [7:0] a_en = {IDX_ENABLE, 2'h0};
  localparam logic [7:0] a_sel = {IDX_EDGE_SEL, 2'h0};
  localparam logic [7:0] a_mode = {IDX_MODE, 2'h0};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr, r;
  logic [31:0] pwdata, prdata;
  logic [3:0] button_in, pos_done;
  logic [15:0] ax_count, ay_count, bx_count, by_count;
  int err_count = 0;
  int total_checks = 0;
  game_irq_ctrl game_irq_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .button_in, .pos_done, .ax_count, .ay_count, .bx_count,
    .by_count, .irq);
  joystick_model joystick_model_i (.pclk, .button_in, .pos_done, .ax_count, .ay_count,
    .bx_count, .by_count);
  // Free-running 25 MHz clock.
  always #20 pclk = ~pclk;
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge before the next request, so psel is never lowered and raised at once.
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00, r, e);
    chk($sformatf("addr %h", a), x, r);
    // Read data holds until the next setup, so the upper lanes can be checked here.
    chk("rdata upper", 8'h00, {7'h0, |prdata[31:8]});
  endtask
  // Look at irq mid-cycle, where the edge's updates have landed.
  task automatic ci(input logic x);
    @(negedge pclk);
    chk("irq", {7'h0, x}, {7'h0, irq});
    @(posedge pclk);
  endtask
  task automatic t_reset();
    rd(a_en, 8'h00);
    rd(a_st, 8'h00);
    wr(a_en, 8'hFF);
    rd(a_en, 8'hF7);
    apb(1'b0, 8'h80, 8'h00, r, e);
    chk("unmapped err", 8'h01, {7'h0, e});
    apb(1'b1, 8'h0D, 8'h00, r, e);
    chk("unaligned err", 8'h01, {7'h0, e});
  endtask
  task automatic t_legacy();
    wr(a_en, 8'h03);
    joystick_model_i.done(4'h3, 16'h0101);
    ci(1'b0);
    rd(a_st, 8'h00);
  endtask
  task automatic t_pos();
    wr(a_mode, 8'h01);
    rd(a_mode, 8'h01);
    wr(a_en, 8'h01);
    joystick_model_i.done(4'h1, 16'hA55A);
    ci(1'b0);
    rd(8'h10, 8'h5A);
    wr(a_en, 8'h05);
    ci(1'b1);
    joystick_model_i.done(4'h2, 16'h1234);
    wr(a_en, 8'h00);
    ci(1'b0);
    rd(8'h14, 8'hA5);
    rd(8'h1C, 8'h12);
    rd(a_st, 8'h00);
    wr(a_en, 8'h06);
    joystick_model_i.done(4'h4, 16'h0F0F);
    ci(1'b1);
    rd(8'h24, 8'h0F);
    ci(1'b0);
  endtask
  task automatic t_btn();
    for (int c = 0; c < 4; c++) begin
      wr(a_sel, {4{c[1:0]}});
      joystick_model_i.press(4'hF);
      repeat (3) @(posedge pclk);
      rd(a_st, c[0] ? 8'hF0 : 8'h00);
      wr(a_st, 8'hF0);
      joystick_model_i.press(4'h0);
      repeat (3) @(posedge pclk);
      rd(a_st, c[1] ? 8'hF0 : 8'h00);
      wr(a_st, 8'hF0);
    end
    wr(a_sel, 8'h55);
    rd(a_sel, 8'h55);
    for (int i = 0; i < 4; i++) begin
      wr(a_en, 8'h10 << i);
      joystick_model_i.press(4'hF);
      repeat (3) @(posedge pclk);
      ci(1'b1);
      wr(a_st, 8'h10 << i);
      ci(1'b0);
      rd(a_st, 8'hF0 & ~(8'h10 << i));
      wr(a_st, 8'hF0);
      joystick_model_i.press(4'h0);
    end
  endtask
  task automatic results();
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the tests need well under this.
  initial begin
    #400000;
    err_count++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_legacy();
    t_pos();
    t_btn();
    results();
  end
endmodule
